// file: hw/erw_pkg.sv
package erw_pkg;

  // ==========================================================================
  // Timing counts, widths and reset values
  // ==========================================================================
  // Phases of a whole bus clock output period (two phases, high and low)
  localparam int unsigned PHASES_PER_BUS_CLK = 2;
  // Base cycle length in bus clock periods before wait states
  localparam int unsigned BASE_CYCLE_CLKS    = 2;
  // Width of the programmed memory cycle wait count
  localparam int unsigned WAIT_W             = 4;
  // Reset value of the phase divider
  localparam logic [7:0]  DIV_RST            = 8'h00;
  // Reset value of the wait counter
  localparam logic [WAIT_W-1:0] WAIT_RST     = 4'h0;
  // Responder's minimum asynchronous ready low time, in ns (2 periods + 14)
  localparam int unsigned ASYNC_RDY_EXTRA_NS = 14;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Programmed characteristics of one external bus cycle
  typedef struct packed {
    logic [WAIT_W-1:0] wait_count; // memory_cycle_wait_count
    logic              cmd_delay;  // Command asserts one bus clock later
    logic              muxed;      // Multiplexed address/data bus
    logic              tristate;   // tristate_turnaround_wait enabled
    logic              is_write;   // Write command rather than read
    logic              async_rdy;  // Ready input treated as asynchronous
    logic              rdy_en;     // Ready controlled cycle
  } erw_cfg_t;

  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DLY   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_SAMP  = 3'b100,
    ST_MUXTA = 3'b101,
    ST_TRI   = 3'b110
  } erw_state_t;

endpackage

// file: hw/erw_sync.sv
`timescale 1ns/1ps

// Two flip-flop synchroniser for one level from outside the clock domain
module erw_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock, reset, enable
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // Level in and out
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_q; // First stage, read only by the second

  // ==========================================================================
  // Synchroniser stages
  // ==========================================================================
  // Two stages; the first is never looked at by other logic
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// file: hw/erw_ctrl.sv
`timescale 1ns/1ps

module erw_ctrl #(
  parameter int unsigned CLK_DIV = 5 // Core clocks per bus clock phase
) (
  // Clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  // Cycle request from the core
  input  wire logic              req_in,
  input  wire erw_pkg::erw_cfg_t cfg_in,
  output logic                   busy_out,
  output logic                   done_out,
  // External pins
  input  wire logic              ready_n_in,
  output logic                   system_clock_output_out,
  output logic                   ale_out,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  output logic                   addr_data_turnaround_state_out,
  output logic                   tristate_turnaround_wait_out
);

  import erw_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0]        div_q, div_d;       // Phase divider
  logic              clk_q, clk_d;       // Bus clock output level
  logic              rise_tick;          // Bus clock rises next core edge
  erw_state_t        st_q, st_d;         // Sequencer state
  erw_cfg_t          cfg_q, cfg_d;       // Latched cycle settings
  logic [WAIT_W-1:0] wcnt_q, wcnt_d;     // Remaining wait states
  logic              ale_q, ale_d;       // Address latch enable
  logic              rd_q, rd_d;         // Read strobe, active low
  logic              wr_q, wr_d;         // Write strobe, active low
  logic              done_q, done_d;     // Cycle ended pulse
  logic              rdy_sync;           // Ready after two flops
  logic              rdy_pin_q, rdy_pin_d; // Ready sampled on bus clock rise
  logic              rdy_used;           // Ready value seen at sample point

  // ==========================================================================
  // Ready input conditioning
  // ==========================================================================
  // The ready pin passes two flops in both modes, plus the bus clock rise capture in sync mode; async mode then relies on the synchroniser
  erw_sync #(
    .RST_VAL (1'b1)
  ) u_rdy_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .ce_in   (ce_in),
    .d_in    (ready_n_in),
    .q_out   (rdy_sync)
  );

  // Synchronous ready is captured at the bus clock rising edge only
  always_comb begin
    rdy_pin_d = rise_tick ? rdy_sync : rdy_pin_q;
  end

  // Select ready source by mode
  always_comb begin
    rdy_used = cfg_q.async_rdy ? rdy_sync : rdy_pin_q;
  end

  // ==========================================================================
  // Bus clock output divider
  // ==========================================================================
  // Toggle the bus clock every CLK_DIV core cycles
  always_comb begin
    rise_tick = 1'b0;
    if (div_q == 8'(CLK_DIV - 1)) begin
      div_d     = DIV_RST;
      clk_d     = ~clk_q;
      rise_tick = ~clk_q;
    end else begin
      div_d = div_q + 8'h01;
      clk_d = clk_q;
    end
  end

  // ==========================================================================
  // Bus cycle sequencer, one step per bus clock period
  // ==========================================================================
  always_comb begin
    st_d   = st_q;
    cfg_d  = cfg_q;
    wcnt_d = wcnt_q;
    ale_d  = ale_q;
    rd_d   = rd_q;
    wr_d   = wr_q;
    done_d = 1'b0;
    if (rise_tick) begin
      case (st_q)
        // Accept a request only when all turnaround states are over
        ST_IDLE: begin
          if (req_in) begin
            cfg_d  = cfg_in;
            wcnt_d = cfg_in.wait_count;
            ale_d  = 1'b1;
            st_d   = ST_ADDR;
          end
        end
        // Address phase; command asserts now unless delayed
        ST_ADDR: begin
          ale_d = 1'b0;
          if (cfg_q.cmd_delay) begin
            st_d = ST_DLY;
          end else begin
            rd_d = cfg_q.is_write;
            wr_d = ~cfg_q.is_write;
            st_d = (wcnt_q == WAIT_RST) ? ST_SAMP : ST_WAIT;
          end
        end
        // Delayed command edge, one bus clock later
        ST_DLY: begin
          rd_d = cfg_q.is_write;
          wr_d = ~cfg_q.is_write;
          st_d = (wcnt_q == WAIT_RST) ? ST_SAMP : ST_WAIT;
        end
        // Programmed memory cycle wait states; zero skips this state
        ST_WAIT: begin
          wcnt_d = wcnt_q - 4'h1;
          if (wcnt_q == 4'h1) begin
            st_d = ST_SAMP;
          end
        end
        // Ready sample point: high stretches, low ends the cycle
        ST_SAMP: begin
          if (!cfg_q.rdy_en || !rdy_used) begin
            rd_d   = 1'b1; // Rising command edge lets responder drop ready
            wr_d   = 1'b1;
            done_d = 1'b1;
            st_d   = cfg_q.muxed ? ST_MUXTA : ST_IDLE;
          end
        end
        // Address/data turnaround after a multiplexed cycle
        ST_MUXTA: begin
          st_d = cfg_q.tristate ? ST_TRI : ST_IDLE;
        end
        // Optional tristate wait before the next cycle
        ST_TRI: begin
          st_d = ST_IDLE;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q     <= DIV_RST;
      clk_q     <= 1'b0;
      st_q      <= ST_IDLE;
      cfg_q     <= '0;
      wcnt_q    <= WAIT_RST;
      ale_q     <= 1'b0;
      rd_q      <= 1'b1;
      wr_q      <= 1'b1;
      done_q    <= 1'b0;
      rdy_pin_q <= 1'b1;
    end else if (ce_in) begin
      div_q     <= div_d;
      clk_q     <= clk_d;
      st_q      <= st_d;
      cfg_q     <= cfg_d;
      wcnt_q    <= wcnt_d;
      ale_q     <= ale_d;
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      done_q    <= done_d;
      rdy_pin_q <= rdy_pin_d;
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Outputs are registered copies so each comes from a flip-flop
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      system_clock_output_out        <= 1'b0;
      ale_out                        <= 1'b0;
      rd_n_out                       <= 1'b1;
      wr_n_out                       <= 1'b1;
      busy_out                       <= 1'b0;
      done_out                       <= 1'b0;
      addr_data_turnaround_state_out <= 1'b0;
      tristate_turnaround_wait_out   <= 1'b0;
    end else if (ce_in) begin
      system_clock_output_out        <= clk_d;
      ale_out                        <= ale_d;
      rd_n_out                       <= rd_d;
      wr_n_out                       <= wr_d;
      busy_out                       <= (st_d != ST_IDLE);
      done_out                       <= done_d;
      addr_data_turnaround_state_out <= (st_d == ST_MUXTA);
      tristate_turnaround_wait_out   <= (st_d == ST_TRI);
    end
  end

endmodule

// file: verification/erw_ready_model.sv
`timescale 1ns/1ps
// ==========
// Responder that drives the ready pin from its own link clock
module erw_ready_model (
  // Link clock and command strobes
  input  wire logic       link_clk_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  // Link cycles to keep ready off after the command falls
  input  wire logic [3:0] hold_in,
  // Ready pin, pulled up when released
  output logic            ready_n_out
);
  logic [3:0] cnt_q; // Link cycles since the command fell
  logic       low_q; // Ready driven low
  logic       idle;  // No command active
  assign idle = rd_n_in & wr_n_in;
  // Ready stays low until the command rises, then the pull-up wins
  assign ready_n_out = idle | ~low_q;
  // Count link cycles, assert ready once the hold has run out
  always_ff @(posedge link_clk_in or posedge idle) begin
    if (idle) begin
      cnt_q <= 4'h0;
      low_q <= 1'b0;
    end else if (cnt_q >= hold_in) begin
      low_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// file: verification/erw_ctrl_assertions.sv
`timescale 1ns/1ps
// ==========
// Pin timing checks on the bus cycle sequencer
module erw_ctrl_assertions (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic system_clock_output_out,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic addr_data_turnaround_state_out,
  input wire logic tristate_turnaround_wait_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Bus clock rising and command ending
  sequence s_bclk_rise; $rose(system_clock_output_out); endsequence
  sequence s_cmd_end; $rose(rd_n_out) || $rose(wr_n_out); endsequence
  property p_one_cmd; !(!rd_n_out && !wr_n_out); endproperty
  property p_done_end; done_out |-> s_cmd_end; endproperty
  property p_end_edge; s_cmd_end |-> s_bclk_rise; endproperty
  property p_cmd_edge; $fell(rd_n_out) || $fell(wr_n_out) |-> s_bclk_rise; endproperty
  property p_ale_edge; $fell(ale_out) |-> s_bclk_rise; endproperty
  property p_ale_busy; ale_out |-> busy_out && rd_n_out && wr_n_out; endproperty
  property p_turn_done; $rose(addr_data_turnaround_state_out) |-> done_out; endproperty
  property p_tri_turn;
    $rose(tristate_turnaround_wait_out) |-> $fell(addr_data_turnaround_state_out);
  endproperty
  property p_gap;
    addr_data_turnaround_state_out || tristate_turnaround_wait_out
      |-> busy_out && !ale_out && rd_n_out && wr_n_out;
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("both strobes low");
  a_done_end: assert property (p_done_end) else $error("done without end");
  a_end_edge: assert property (p_end_edge) else $error("end off edge");
  a_cmd_edge: assert property (p_cmd_edge) else $error("command off edge");
  a_ale_edge: assert property (p_ale_edge) else $error("ale off edge");
  a_ale_busy: assert property (p_ale_busy) else $error("ale misplaced");
  a_turn_done: assert property (p_turn_done) else $error("turnaround early");
  a_tri_turn: assert property (p_tri_turn) else $error("tristate order");
  a_gap: assert property (p_gap) else $error("cycle in turnaround");
endmodule

bind erw_ctrl erw_ctrl_assertions i_chk (.*);

// file: verification/erw_ctrl_tb.sv
`timescale 1ns/1ps
// ==========
// Bench for the bus cycle sequencer
module erw_ctrl_tb;
  import erw_pkg::*;
  typedef struct {erw_cfg_t cfg; int cmd; int done;} erw_row_t;
  logic mclk = 0, rst = 1, req = 0, lclk = 0, ce = 1;
  logic [2:0] snap; // Outputs captured before the clock enable drops
  erw_cfg_t cfg = '0;
  logic [3:0] hold = 4'h0;
  logic busy, done, rdy_n, bclk, ale, rd_n, wr_n, turn, tri_w, rd_s, wr_s, turn_s, tri_s;
  int fails = 0, compares = 0, cmd_at, done_at, end_at, ready_at, r;
  // Cycle settings and expected command and end points, in bus clocks
  erw_row_t rows[6] = '{'{10'h000, 1, 2}, '{10'h024, 2, 3}, '{10'h0d8, 1, 5},
                        '{10'h3f4, 2, 18}, '{10'h081, 1, 4}, '{10'h07f, 2, 4}};
  always #2 mclk = ~mclk;
  always #40 lclk = ~lclk;
  erw_ctrl #(.CLK_DIV(2)) i_dut (.mclk_in(mclk), .rst_in(rst), .ce_in(ce), .req_in(req),
    .cfg_in(cfg), .busy_out(busy), .done_out(done), .ready_n_in(rdy_n),
    .system_clock_output_out(bclk), .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .addr_data_turnaround_state_out(turn), .tristate_turnaround_wait_out(tri_w));
  erw_ready_model i_resp (.link_clk_in(lclk), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .hold_in(hold), .ready_n_out(rdy_n));
  // Verdict and end of run
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Count in range, and single bit
  task automatic chk(input string n, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi) begin
      fails++;
      $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic chk_b(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  // One bus cycle, counting bus clock rises from acceptance
  task automatic run(input erw_cfg_t c);
    int n;
    logic pb;
    cfg = c;
    req = 1;
    n = 0;
    while (busy !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    req = 0;
    // A request that is never taken counts as a timeout
    if (busy !== 1'b1) n = 500;
    pb = 1;
    r = 0;
    cmd_at = -1;
    done_at = -1;
    ready_at = -1;
    {rd_s, wr_s, turn_s, tri_s} = '0;
    while (busy === 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
      if (bclk && !pb) r++;
      pb = bclk;
      if (ready_at < 0 && rdy_n === 1'b0) ready_at = r;
      if (cmd_at < 0 && !(rd_n && wr_n)) cmd_at = r;
      rd_s |= !rd_n;
      wr_s |= !wr_n;
      turn_s |= turn;
      tri_s |= tri_w;
      if (done) done_at = r;
    end
    end_at = r;
    if (n >= 500) begin
      fails++;
      results();
    end
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst = 0;
    foreach (rows[i]) begin
      run(rows[i].cfg);
      chk("cmd", rows[i].cmd, rows[i].cmd, cmd_at);
      chk("done", rows[i].done, rows[i].done + (rows[i].cfg.rdy_en ? 12 : 0), done_at);
      chk_b("rd", !cfg.is_write, rd_s);
      chk_b("wr", cfg.is_write, wr_s);
      chk_b("turn", cfg.muxed, turn_s);
      chk_b("tristate", cfg.muxed & cfg.tristate, tri_s);
      chk("gap", int'(cfg.muxed) + int'(cfg.muxed & cfg.tristate), 99, end_at - done_at);
      $display("row %0d finished", i);
      repeat (40) @(negedge mclk);
    end
    // Slow responder, synchronous then asynchronous ready
    hold = 4'h3;
    for (int a = 0; a < 2; a++) begin
      run(a ? 10'h003 : 10'h001);
      chk("slow done", 16, 25, done_at);
      chk("ready to end", a ? 1 : 2, a ? 2 : 3, done_at - ready_at);
      $display("slow ready %0d finished", a);
      repeat (40) @(negedge mclk);
    end
    // Clock enable low freezes a running cycle, then reset cuts it
    cfg = 10'h3c0;
    req = 1;
    repeat (12) @(negedge mclk);
    chk_b("busy before reset", 1'b1, busy);
    chk_b("strobe before reset", 1'b0, rd_n);
    snap = {bclk, rd_n, busy};
    ce = 0;
    repeat (6) @(negedge mclk);
    chk_b("frozen", 1'b1, snap === {bclk, rd_n, busy});
    ce = 1;
    rst = 1;
    @(negedge mclk);
    chk_b("idle outputs", 1'b0, |{busy, done, ale, bclk, turn, tri_w});
    chk_b("strobes", 1'b1, rd_n & wr_n);
    req = 0;
    rst = 0;
    @(negedge mclk);
    chk_b("released", 1'b0, |{busy, done, ale, bclk});
    run(10'h000);
    chk("done after reset", 2, 2, done_at);
    $display("mid-cycle reset finished");
    results();
  end
endmodule
